//--- dv/ccs_host_model.sv
// host side model: counts interrupt pulses and measures their width
`timescale 1ns/1ps
module ccs_host_model (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // interrupt from the sequencer
   input wire logic int_n,
   // what the host has seen
   output logic [15:0] int_count,
   output logic [15:0] last_width
);
   logic [15:0] width;
   logic int_q;
   // the host only sees edges, so a retriggered pulse counts once
   always_ff @(posedge clock) begin
      if (!nrst) begin
         int_q <= 1'b1;
         width <= 16'h0;
         int_count <= 16'h0;
         last_width <= 16'h0;
      end else begin
         int_q <= int_n;
         if (!int_n) begin
            width <= width + 16'h1;
         end
         if (int_q && !int_n) begin
            int_count <= int_count + 16'h1;
         end
         if (!int_q && int_n) begin
            last_width <= width;
            width <= 16'h0;
         end
      end
   end
endmodule

//--- dv/ccs_top_asserts.sv
// concurrent checks on the charge cycle sequencer ports
`timescale 1ns/1ps
module ccs_top_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // inputs watched
   input wire logic input_current_regulation,
   input wire logic input_voltage_regulation,
   input wire logic thermal_regulation,
   input wire logic remote_sense_disable,
   input wire logic thermistor_ignore,
   // outputs watched
   input wire logic [1:0] charge_phase_status,
   input wire logic topoff_running_flag,
   input wire logic [1:0] charge_fault_field,
   input wire logic [2:0] thermistor_fault_status,
   input wire logic [2:0] input_source_status,
   input wire logic remote_sense_active,
   input wire logic boost_suspend,
   input wire logic status_pin_oe,
   input wire logic int_n
);
   logic [15:0] low_cnt;
   wire logic regulating = input_current_regulation | input_voltage_regulation |
      thermal_regulation;
   ////////////////////////////////////////////////////////////////////////////
   // width of the current interrupt pulse, cleared in reset so a cut pulse never counts
   always_ff @(posedge clock) begin
      if (!nrst || int_n) begin
         low_cnt <= 16'h0;
      end else begin
         low_cnt <= low_cnt + 16'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////
   a_int_pulse_width: assert property ($rose(int_n) |-> low_cnt >= 16'h1900)
      else $error("interrupt pulse shorter than 6400 cycles");
   a_done_int: assert property ($rose(charge_phase_status == ccs_pkg::PHASE_DONE)
      |-> ##[0:2] !int_n) else $error("no interrupt at termination");
   a_done_status_high: assert property (charge_phase_status == ccs_pkg::PHASE_DONE
      |-> ##[0:1] !status_pin_oe) else $error("status pin low after termination");
   a_term_suppressed: assert property (regulating [*5]
      |=> !$rose(charge_phase_status == ccs_pkg::PHASE_DONE))
      else $error("termination during regulation");
   a_timer_fault_int: assert property ($rose(charge_fault_field == ccs_pkg::FAULT_TIMER)
      |-> ##[0:2] !int_n) else $error("no interrupt at timer expiry");
   a_topoff_start_int: assert property ($rose(topoff_running_flag) |-> ##[0:2] !int_n)
      else $error("no interrupt at top-off start");
   a_topoff_status_high: assert property (topoff_running_flag |-> !status_pin_oe)
      else $error("status pin low during top-off");
   a_boost_source_none: assert property (boost_suspend
      |-> input_source_status == ccs_pkg::SRC_NONE) else $error("source status in suspend");
   a_sense_disabled: assert property (remote_sense_disable [*4] |-> !remote_sense_active)
      else $error("remote sense active while disabled");
   a_ignore_no_fault: assert property (thermistor_ignore [*4]
      |-> thermistor_fault_status == ccs_pkg::TH_FAULT_NONE)
      else $error("thermistor fault while ignored");
endmodule

bind ccs_top ccs_top_asserts ccs_top_asserts_i (.clock, .nrst, .input_current_regulation,
   .input_voltage_regulation, .thermal_regulation, .remote_sense_disable, .thermistor_ignore,
   .charge_phase_status, .topoff_running_flag, .charge_fault_field, .thermistor_fault_status,
   .input_source_status, .remote_sense_active, .boost_suspend, .status_pin_oe, .int_n);

//--- dv/testbench.sv
// self-checking testbench for the charge cycle sequencer
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0, nrst = 1'b0;
   logic bat_below_short = 1'b0, bat_below_pre = 1'b0, bat_below_low = 1'b0;
   logic bat_above_rechg = 1'b0, cur_below_term = 1'b0, input_current_regulation = 1'b0;
   logic input_voltage_regulation = 1'b0, thermal_regulation = 1'b0, battery_fault_flag = 1'b0;
   logic sense_valid = 1'b1, adapter_present = 1'b1, boost_mode = 1'b0;
   logic push_button_input = 1'b1, th_below_t1 = 1'b0, th_below_t2 = 1'b0, th_above_t3 = 1'b0;
   logic th_above_t5 = 1'b0, th_boost_out = 1'b0, charge_enable_bit = 1'b0;
   logic charge_enable_pin_n = 1'b0, term_enable = 1'b1, remote_sense_disable = 1'b0;
   logic [3:0] term_current = 4'h2;
   logic [1:0] topoff_select = 2'h1, cool_current_fraction = 2'h1, warm_current_fraction = 2'h3;
   logic warm_voltage_select = 1'b1, thermistor_ignore = 1'b0, fast_timer_length_select = 1'b0;
   logic timer_enable = 1'b1, half_rate_enable = 1'b1, switch_disable_bit = 1'b0;
   logic switch_off_delay_bit = 1'b0, adapter_ship_bit = 1'b0, system_reset_enable = 1'b0;
   logic reset_with_adapter_bit = 1'b0, register_reset = 1'b0;
   logic [1:0] charge_phase_status, charge_fault_field, current_fraction;
   logic [2:0] thermistor_fault_status, input_source_status;
   logic [3:0] term_current_level;
   logic topoff_running_flag, high_impedance_set, reduced_voltage, remote_sense_active;
   logic battery_switch_on, boost_suspend, registers_to_default, status_pin_out;
   logic status_pin_oe, int_n;
   logic [15:0] int_count, last_width, k;
   int num_errors = 0, n_compared = 0, cycles = 0, i;
   ccs_top #(.SAFE_LOW_S(100), .SAFE_10H_S(250), .SAFE_20H_S(500), .TOPOFF_15M_S(2),
      .TICK_CYC(4), .DEGLITCH_CYC(4), .RST_HOLD_CYC(20), .RST_OFF_CYC(10),
      .SHIP_DELAY_CYC(10), .BLINK_HALF_CYC(8)) ccs_top_i (.*);
   ccs_host_model ccs_host_model_i (.clock(clock), .nrst(nrst), .int_n(int_n),
      .int_count(int_count), .last_width(last_width));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clock = ~clock;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // a run of about 9000 cycles is expected, so this only cuts a real hang
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic poll(ref logic sig, input logic val, input int lim);
      for (int j = 0; j < lim && sig !== val; j++) @(posedge clock);
      chk(sig, val);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      step(16);
      nrst <= 1'b1;
      step(5);
      chk({charge_phase_status, current_fraction}, 4'h3);
      chk({int_n, battery_switch_on, remote_sense_active}, 3'h7);
      sense_valid <= 1'b0;
      term_current <= 4'h9;
      step(6);
      chk(remote_sense_active, 1'b0);
      chk(term_current_level, 4'h9);
      sense_valid <= 1'b1;
      remote_sense_disable <= 1'b1;
      step(6);
      chk(remote_sense_active, 1'b0);
      remote_sense_disable <= 1'b0;
      bat_below_pre <= 1'b1;
      charge_enable_bit <= 1'b1;
      step(6);
      chk(charge_phase_status, 2'h1);
      charge_enable_bit <= 1'b0;
      bat_below_pre <= 1'b0;
      step(6);
      charge_enable_bit <= 1'b1;
      step(6);
      chk({charge_phase_status, status_pin_oe}, 3'h5);
      $display("test phase over");
      th_below_t2 <= 1'b1;
      step(6);
      chk(current_fraction, 2'h1);
      th_below_t2 <= 1'b0;
      th_above_t3 <= 1'b1;
      warm_voltage_select <= 1'b0;
      warm_current_fraction <= 2'h2;
      cool_current_fraction <= 2'h0;
      step(6);
      chk({reduced_voltage, current_fraction}, 3'h6);
      th_above_t3 <= 1'b0;
      th_below_t1 <= 1'b1;
      th_below_t2 <= 1'b1;
      step(6);
      chk(thermistor_fault_status, 3'h5);
      chk(current_fraction, 2'h0);
      th_below_t1 <= 1'b0;
      th_below_t2 <= 1'b0;
      th_above_t5 <= 1'b1;
      step(6);
      chk(thermistor_fault_status, 3'h5);
      thermistor_ignore <= 1'b1;
      step(6);
      chk(thermistor_fault_status, 3'h0);
      th_above_t5 <= 1'b0;
      thermistor_ignore <= 1'b0;
      step(6);
      $display("test zones over");
      k = int_count;
      topoff_select <= 2'h3;
      bat_above_rechg <= 1'b1;
      cur_below_term <= 1'b1;
      input_current_regulation <= 1'b1;
      input_voltage_regulation <= 1'b1;
      thermal_regulation <= 1'b1;
      step(8);
      chk(charge_phase_status, 2'h2);
      term_enable <= 1'b0;
      input_current_regulation <= 1'b0;
      input_voltage_regulation <= 1'b0;
      thermal_regulation <= 1'b0;
      step(8);
      chk(charge_phase_status, 2'h2);
      term_enable <= 1'b1;
      step(6);
      chk({charge_phase_status, status_pin_oe, topoff_running_flag}, 4'hd);
      chk(4'(int_count - k), 4'h1);
      topoff_select <= 2'h0;
      poll(topoff_running_flag, 1'b0, 4);
      step(6600);
      chk({last_width >= 16'd6400, last_width < 16'd6480}, 2'h3);
      $display("test termination over");
      bat_above_rechg <= 1'b0;
      half_rate_enable <= 1'b0;
      charge_enable_pin_n <= 1'b1;
      step(4);
      charge_enable_pin_n <= 1'b0;
      step(600);
      chk(charge_fault_field, 2'h0);
      battery_fault_flag <= 1'b1;
      step(500);
      chk(charge_fault_field, 2'h0);
      battery_fault_flag <= 1'b0;
      for (i = 0; i < 1000 && charge_fault_field !== 2'h3; i++) @(posedge clock);
      chk(charge_fault_field, 2'h3);
      bat_below_low <= 1'b1;
      charge_enable_bit <= 1'b0;
      step(4);
      charge_enable_bit <= 1'b1;
      step(300);
      chk(charge_fault_field, 2'h0);
      for (i = 0; i < 200 && charge_fault_field !== 2'h3; i++) @(posedge clock);
      chk(charge_fault_field, 2'h3);
      charge_enable_bit <= 1'b0;
      $display("test safety timer over");
      boost_mode <= 1'b1;
      th_boost_out <= 1'b1;
      step(6);
      chk({boost_suspend, input_source_status}, 4'h8);
      th_boost_out <= 1'b0;
      step(6);
      chk({boost_suspend, input_source_status}, 4'h7);
      boost_mode <= 1'b0;
      timer_enable <= 1'b0;
      $display("test boost over");
      adapter_ship_bit <= 1'b1;
      step(2);
      switch_off_delay_bit <= 1'b1;
      switch_disable_bit <= 1'b1;
      poll(battery_switch_on, 1'b0, 40);
      adapter_present <= 1'b0;
      step(6);
      push_button_input <= 1'b0;
      step(10);
      push_button_input <= 1'b1;
      poll(battery_switch_on, 1'b1, 40);
      chk(high_impedance_set, 1'b1);
      switch_disable_bit <= 1'b0;
      adapter_ship_bit <= 1'b0;
      system_reset_enable <= 1'b1;
      reset_with_adapter_bit <= 1'b1;
      step(4);
      push_button_input <= 1'b0;
      poll(battery_switch_on, 1'b0, 60);
      push_button_input <= 1'b1;
      poll(battery_switch_on, 1'b1, 40);
      $display("test ship mode over");
      wrap_up();
   end
endmodule

//--- hdl/ccs_pkg.sv
// constants and types shared by the charge cycle sequencer
package ccs_pkg;
   // charge phase codes
   localparam logic [1:0] PHASE_OFF = 2'h0;
   localparam logic [1:0] PHASE_PRE = 2'h1;
   localparam logic [1:0] PHASE_FAST = 2'h2;
   localparam logic [1:0] PHASE_DONE = 2'h3;
   // charge fault field codes
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_TIMER = 2'h3;
   // current fractions
   localparam logic [1:0] FRAC_0 = 2'h0;
   localparam logic [1:0] FRAC_20 = 2'h1;
   localparam logic [1:0] FRAC_50 = 2'h2;
   localparam logic [1:0] FRAC_100 = 2'h3;
   // termination current field position
   localparam int TERM_LSB = 0;
   localparam int TERM_MSB = 3;
   localparam logic [3:0] TERM_DEFAULT = 4'h2;
   localparam logic [2:0] TH_FAULT_NONE = 3'h0;
   localparam logic [2:0] TH_FAULT_OUT = 3'h5;
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_BOOST = 3'h7;
   // timing
   localparam int CLK_HZ = 25000000;
   localparam int INT_PULSE_US = 256;
   localparam int INT_PULSE_CYC = INT_PULSE_US * (CLK_HZ / 1000000);
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
   localparam int TICK_S = 1;
   localparam int TICK_CYC = TICK_S * CLK_HZ;
   localparam int SAFE_LOW_S = 7200;
   localparam int SAFE_10H_S = 36000;
   localparam int SAFE_20H_S = 72000;
   localparam int TOPOFF_15M_S = 900;
   localparam int DEGLITCH_MS = 10;
   localparam int DEGLITCH_CYC = DEGLITCH_MS * (CLK_HZ / 1000);
   localparam int RST_HOLD_MS = 10000;
   localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
   localparam int RST_OFF_MS = 250;
   localparam int RST_OFF_CYC = RST_OFF_MS * (CLK_HZ / 1000);
   localparam int SHIP_DELAY_MS = 10000;
   localparam int SHIP_DELAY_CYC = SHIP_DELAY_MS * (CLK_HZ / 1000);

   typedef enum logic [4:0] {
      SW_ON = 5'h01,
      SW_SHIP_WAIT = 5'h02,
      SW_SHIP = 5'h04,
      SW_RST_HIZ = 5'h08,
      SW_RST_OFF = 5'h10
   } ccs_sw_t;
endpackage

//--- hdl/ccs_tick.sv
// gated seconds tick shared by the safety and top-off timers
`timescale 1ns/1ps
module ccs_tick #(
   parameter int TICK_CYC = ccs_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // timebase
   ccs_tick_if.gen tb
);
   typedef struct packed {
      logic [31:0] div;
      logic odd;
      logic tick;
   } ccs_tick_st_t;
   ccs_tick_st_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      // the divider freezes while paused so both timers stop together
      if (tb.run) begin
         if (s.div >= 32'(TICK_CYC - 1)) begin
            next_s.div = 32'h0;
            next_s.odd = ~s.odd;
            next_s.tick = ~tb.half | s.odd;
         end else begin
            next_s.div = s.div + 32'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tb.tick = s.tick;
endmodule

//--- hdl/ccs_tick_if.sv
// timebase handshake between the sequencer and its tick generator
`timescale 1ns/1ps
interface ccs_tick_if;
   logic run;
   logic half;
   logic tick;
   modport gen (input run, input half, output tick);
   modport user (output run, output half, input tick);
endinterface

//--- hdl/ccs_top.sv
// charge cycle sequencer: phases, termination, timers, thermistor zones, ship mode
`timescale 1ns/1ps
module ccs_top #(
   parameter int SAFE_LOW_S = ccs_pkg::SAFE_LOW_S,
   parameter int SAFE_10H_S = ccs_pkg::SAFE_10H_S,
   parameter int SAFE_20H_S = ccs_pkg::SAFE_20H_S,
   parameter int TOPOFF_15M_S = ccs_pkg::TOPOFF_15M_S,
   parameter int TICK_CYC = ccs_pkg::TICK_CYC,
   parameter int DEGLITCH_CYC = ccs_pkg::DEGLITCH_CYC,
   parameter int RST_HOLD_CYC = ccs_pkg::RST_HOLD_CYC,
   parameter int RST_OFF_CYC = ccs_pkg::RST_OFF_CYC,
   parameter int SHIP_DELAY_CYC = ccs_pkg::SHIP_DELAY_CYC,
   parameter int BLINK_HALF_CYC = ccs_pkg::BLINK_HALF_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // analog comparator results (asynchronous)
   input wire logic bat_below_short,
   input wire logic bat_below_pre,
   input wire logic bat_below_low,
   input wire logic bat_above_rechg,
   input wire logic cur_below_term,
   input wire logic input_current_regulation,
   input wire logic input_voltage_regulation,
   input wire logic thermal_regulation,
   input wire logic battery_fault_flag,
   input wire logic sense_valid,
   input wire logic adapter_present,
   input wire logic boost_mode,
   input wire logic push_button_input,
   // thermistor zones (asynchronous)
   input wire logic th_below_t1,
   input wire logic th_below_t2,
   input wire logic th_above_t3,
   input wire logic th_above_t5,
   input wire logic th_boost_out,
   // settings from host
   input wire logic charge_enable_bit,
   input wire logic charge_enable_pin_n,
   input wire logic term_enable,
   input wire logic [3:0] term_current,
   input wire logic [1:0] topoff_select,
   input wire logic remote_sense_disable,
   input wire logic [1:0] cool_current_fraction,
   input wire logic [1:0] warm_current_fraction,
   input wire logic warm_voltage_select,
   input wire logic thermistor_ignore,
   input wire logic fast_timer_length_select,
   input wire logic timer_enable,
   input wire logic half_rate_enable,
   input wire logic switch_disable_bit,
   input wire logic switch_off_delay_bit,
   input wire logic adapter_ship_bit,
   input wire logic system_reset_enable,
   input wire logic reset_with_adapter_bit,
   input wire logic register_reset,
   // status to host
   output logic [1:0] charge_phase_status,
   output logic topoff_running_flag,
   output logic [1:0] charge_fault_field,
   output logic [2:0] thermistor_fault_status,
   output logic [2:0] input_source_status,
   output logic high_impedance_set,
   output logic [3:0] term_current_level,
   // analog controls
   output logic [1:0] current_fraction,
   output logic reduced_voltage,
   output logic remote_sense_active,
   output logic battery_switch_on,
   output logic boost_suspend,
   output logic registers_to_default,
   // pins
   output logic status_pin_out,
   output logic status_pin_oe,
   output logic int_n
);
   localparam int NS = 18;

   typedef struct packed {
      logic [NS-1:0] m1;
      logic [NS-1:0] m2;
      logic [1:0] phase;
      logic topoff;
      logic [1:0] topoff_len;
      logic [31:0] topoff_cnt;
      logic [31:0] safe_cnt;
      logic [1:0] fault;
      logic [2:0] th_fault;
      logic [2:0] src;
      logic hiz;
      logic [1:0] frac;
      logic vred;
      logic rsense;
      logic term_ok;
      logic en_d;
      logic [31:0] int_cnt;
      logic int_n;
      logic [31:0] blink_cnt;
      logic blink;
      logic stat;
      ccs_pkg::ccs_sw_t sw;
      logic [31:0] sw_cnt;
      logic [31:0] btn_cnt;
      logic btn_d;
      logic [31:0] hold_cnt;
      logic reset_armed;
      logic swon;
      logic bsusp;
      logic defaults;
      logic [3:0] term_lvl;
   } ccs_st_t;

   ccs_st_t s, next_s;
   ccs_tick_if tb();

   ccs_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clock(clock),
      .nrst(nrst),
      .tb(tb.gen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // synchronised inputs
   wire logic [NS-1:0] raw = {bat_below_short, bat_below_pre, bat_below_low,
      bat_above_rechg, cur_below_term, input_current_regulation,
      input_voltage_regulation, thermal_regulation, battery_fault_flag, sense_valid,
      adapter_present, boost_mode, push_button_input, th_below_t1, th_below_t2,
      th_above_t3, th_above_t5, th_boost_out};
   logic b_low, b_pre, rechg, iterm, dpm, bfault, sval, vbus, boost, btn;
   logic cold_hot, cool, warm, bout;
   always_comb begin
      b_pre = s.m2[16];
      b_low = s.m2[15];
      rechg = s.m2[14];
      iterm = s.m2[13];
      dpm = s.m2[12] | s.m2[11] | s.m2[10];
      bfault = s.m2[9];
      sval = s.m2[8];
      vbus = s.m2[7];
      boost = s.m2[6];
      btn = s.m2[5];
      cold_hot = (s.m2[4] | s.m2[1]) & ~thermistor_ignore;
      cool = s.m2[3] & ~thermistor_ignore;
      warm = s.m2[2] & ~thermistor_ignore;
      bout = s.m2[0] & ~thermistor_ignore;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   logic en, charging, evt, safe_exp, top_exp, suspend, halve, btn_fall;
   logic [31:0] safe_lim, top_lim;
   always_comb begin
      next_s = s;
      next_s.m1 = raw;
      next_s.m2 = s.m1;
      evt = 1'b0;
      en = charge_enable_bit & ~charge_enable_pin_n & ~switch_disable_bit;
      next_s.en_d = en;
      next_s.term_lvl = term_current;
      next_s.defaults = 1'b0;
      next_s.rsense = ~remote_sense_disable & sval;

      // thermistor zones
      if (boost) begin
         next_s.th_fault = bout ? ccs_pkg::TH_FAULT_OUT : ccs_pkg::TH_FAULT_NONE;
         next_s.src = bout ? ccs_pkg::SRC_NONE : ccs_pkg::SRC_BOOST;
         next_s.bsusp = bout;
      end else begin
         next_s.th_fault = cold_hot ? ccs_pkg::TH_FAULT_OUT : ccs_pkg::TH_FAULT_NONE;
         next_s.src = ccs_pkg::SRC_NONE;
         next_s.bsusp = 1'b0;
      end
      next_s.frac = cool ? cool_current_fraction :
         (warm ? warm_current_fraction : ccs_pkg::FRAC_100);
      next_s.vred = warm & ~warm_voltage_select;

      suspend = cold_hot | bfault | ~timer_enable;
      halve = half_rate_enable & (dpm | ((cool | warm) & s.frac != ccs_pkg::FRAC_100));
      charging = en & (s.phase != ccs_pkg::PHASE_OFF) & (s.phase != ccs_pkg::PHASE_DONE);
      tb.run = (charging | s.topoff) & ~suspend;
      tb.half = halve;

      // safety timer
      safe_lim = b_low ? 32'(SAFE_LOW_S) :
         (fast_timer_length_select ? 32'(SAFE_20H_S) : 32'(SAFE_10H_S));
      safe_exp = 1'b0;
      if (en & ~s.en_d) begin
         next_s.safe_cnt = 32'h0;
      end else if (charging & tb.tick) begin
         next_s.safe_cnt = s.safe_cnt + 32'h1;
         if (s.safe_cnt + 32'h1 >= safe_lim) begin
            safe_exp = 1'b1;
         end
      end
      if (safe_exp) begin
         next_s.fault = ccs_pkg::FAULT_TIMER;
         next_s.phase = ccs_pkg::PHASE_OFF;
         evt = 1'b1;
      end

      // termination enable is only taken before termination is detected
      if (s.phase != ccs_pkg::PHASE_DONE) begin
         next_s.term_ok = term_enable;
      end

      // phase selection
      if (!en) begin
         next_s.phase = ccs_pkg::PHASE_OFF;
         next_s.topoff = 1'b0;
         next_s.fault = ccs_pkg::FAULT_NONE;
      end else if (s.phase == ccs_pkg::PHASE_OFF) begin
         if (!cold_hot && s.fault == ccs_pkg::FAULT_NONE) begin
            next_s.phase = b_pre ? ccs_pkg::PHASE_PRE : ccs_pkg::PHASE_FAST;
         end
      end else if (s.phase != ccs_pkg::PHASE_DONE && !safe_exp) begin
         next_s.phase = b_pre ? ccs_pkg::PHASE_PRE : ccs_pkg::PHASE_FAST;
         if (rechg && iterm && s.term_ok && !dpm && !warm && !cold_hot) begin
            next_s.phase = ccs_pkg::PHASE_DONE;
            next_s.topoff_len = topoff_select;
            next_s.topoff_cnt = 32'h0;
            next_s.topoff = topoff_select != 2'h0;
            evt = 1'b1;
         end
      end else if (s.phase == ccs_pkg::PHASE_DONE && !rechg) begin
         next_s.phase = ccs_pkg::PHASE_FAST;
         next_s.topoff = 1'b0;
      end

      // top-off timer
      top_lim = 32'(TOPOFF_15M_S) * {30'h0, s.topoff_len};
      top_exp = 1'b0;
      if (s.topoff) begin
         if (topoff_select == 2'h0) begin
            next_s.topoff = 1'b0;
         end else if (tb.tick) begin
            next_s.topoff_cnt = s.topoff_cnt + 32'h1;
            if (s.topoff_cnt + 32'h1 >= top_lim) begin
               next_s.topoff = 1'b0;
               top_exp = 1'b1;
               evt = 1'b1;
            end
         end
      end

      // push button deglitch and falling edge
      btn_fall = 1'b0;
      if (btn == s.btn_d) begin
         next_s.btn_cnt = 32'h0;
      end else if (s.btn_cnt >= 32'(DEGLITCH_CYC - 1)) begin
         next_s.btn_d = btn;
         next_s.btn_cnt = 32'h0;
         btn_fall = s.btn_d & ~btn;
      end else begin
         next_s.btn_cnt = s.btn_cnt + 32'h1;
      end
      if (!s.btn_d && s.hold_cnt < 32'(RST_HOLD_CYC)) begin
         next_s.hold_cnt = s.hold_cnt + 32'h1;
      end else if (s.btn_d) begin
         next_s.hold_cnt = 32'h0;
         next_s.reset_armed = 1'b0;
      end
      if (s.hold_cnt == 32'(RST_HOLD_CYC - 1) && system_reset_enable && !switch_disable_bit) begin
         next_s.reset_armed = 1'b1;
      end
      if (vbus) begin
         next_s.hiz = 1'b0;
      end

      // battery switch sequencing
      case (s.sw)
         ccs_pkg::SW_ON: begin
            next_s.swon = ~(s.phase == ccs_pkg::PHASE_DONE) | ~vbus;
            if (switch_disable_bit && (!vbus || adapter_ship_bit)) begin
               next_s.sw = ccs_pkg::SW_SHIP_WAIT;
               next_s.sw_cnt = 32'h0;
            end else if (s.reset_armed && (reset_with_adapter_bit || !vbus)) begin
               next_s.sw = ccs_pkg::SW_RST_HIZ;
               next_s.reset_armed = 1'b0;
            end
         end
         ccs_pkg::SW_SHIP_WAIT: begin
            if (!switch_disable_bit || register_reset) begin
               next_s.sw = ccs_pkg::SW_ON;
            end else if (!switch_off_delay_bit || s.sw_cnt >= 32'(SHIP_DELAY_CYC - 1)) begin
               next_s.swon = 1'b0;
               if (!vbus) begin
                  next_s.sw = ccs_pkg::SW_SHIP;
               end
            end else begin
               next_s.sw_cnt = s.sw_cnt + 32'h1;
            end
         end
         ccs_pkg::SW_SHIP: begin
            next_s.swon = 1'b0;
            if (vbus || !switch_disable_bit || register_reset || btn_fall) begin
               next_s.sw = ccs_pkg::SW_ON;
               next_s.swon = 1'b1;
               if (btn_fall) begin
                  next_s.hiz = 1'b1;
               end
            end
         end
         ccs_pkg::SW_RST_HIZ: begin
            next_s.hiz = 1'b1;
            next_s.swon = 1'b0;
            next_s.sw_cnt = 32'h0;
            next_s.sw = ccs_pkg::SW_RST_OFF;
         end
         ccs_pkg::SW_RST_OFF: begin
            if (s.sw_cnt >= 32'(RST_OFF_CYC - 1)) begin
               next_s.swon = 1'b1;
               next_s.defaults = 1'b1;
               next_s.sw = ccs_pkg::SW_ON;
            end else begin
               next_s.sw_cnt = s.sw_cnt + 32'h1;
            end
         end
         default: begin
            next_s.sw = ccs_pkg::SW_ON;
         end
      endcase

      // interrupt pulse
      if (evt || (next_s.topoff && !s.topoff)) begin
         next_s.int_cnt = 32'(ccs_pkg::INT_PULSE_CYC);
      end else if (s.int_cnt != 32'h0) begin
         next_s.int_cnt = s.int_cnt - 32'h1;
      end
      next_s.int_n = (next_s.int_cnt == 32'h0);

      // status pin: low while charging, high when done or off, blink on timer fault or cold/hot zone
      if (s.blink_cnt >= 32'(BLINK_HALF_CYC - 1)) begin
         next_s.blink_cnt = 32'h0;
         next_s.blink = ~s.blink;
      end else begin
         next_s.blink_cnt = s.blink_cnt + 32'h1;
      end
      if (s.fault == ccs_pkg::FAULT_TIMER || cold_hot) begin
         next_s.stat = s.blink;
      end else begin
         next_s.stat = ~en | (next_s.phase == ccs_pkg::PHASE_OFF) | next_s.topoff |
            (next_s.phase == ccs_pkg::PHASE_DONE);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s <= '0;
         s.m1 <= {NS{1'b0}} | 18'h00020;
         s.m2 <= {NS{1'b0}} | 18'h00020;
         s.btn_d <= 1'b1;
         s.sw <= ccs_pkg::SW_ON;
         s.swon <= 1'b1;
         s.int_n <= 1'b1;
         s.stat <= 1'b1;
         s.rsense <= 1'b1;
         s.term_ok <= 1'b1;
         s.frac <= ccs_pkg::FRAC_100;
         s.term_lvl <= ccs_pkg::TERM_DEFAULT;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      charge_phase_status = s.phase;
      topoff_running_flag = s.topoff;
      charge_fault_field = s.fault;
      thermistor_fault_status = s.th_fault;
      input_source_status = s.src;
      high_impedance_set = s.hiz;
      term_current_level = s.term_lvl;
      current_fraction = s.frac;
      reduced_voltage = s.vred;
      remote_sense_active = s.rsense;
      battery_switch_on = s.swon;
      boost_suspend = s.bsusp;
      registers_to_default = s.defaults;
      status_pin_out = 1'b0;
      status_pin_oe = ~s.stat;
      int_n = s.int_n;
   end
endmodule
